/* File: rtl/dfp_pkg.sv */
// Purpose: Shared constants and types for the dual-function host and control pin block
// Assumes: APB with 32-bit data, byte addresses, one aligned word per register
// Notes: Offsets and field positions are used by name only
package dfp_pkg;
  localparam logic [7:0] DFP_OFS_CTRL = 8'h00;
  localparam logic [7:0] DFP_OFS_CCHAN = 8'h04;
  localparam logic [7:0] DFP_OFS_STATUS = 8'h08;
  localparam logic [7:0] DFP_OFS_MPBOX = 8'h0C;
  localparam int DFP_CTRL_TE_BIT = 0;
  localparam logic [31:0] DFP_CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] DFP_CCHAN_RST = 4'h1;
  localparam int DFP_MP_WORDS = 4;
  localparam int DFP_MP_AW = 2;
  localparam logic [7:0] DFP_FLAG = 8'h7E;
  localparam logic [2:0] DFP_FLAG_LAST = 3'h7;
  localparam logic [2:0] DFP_BIT_ZERO = 3'h0;
  localparam logic [1:0] DFP_PIN_SYNC_RST = 2'h0;
  localparam logic [7:0] DFP_BYTE_ZERO = 8'h00;
  localparam logic [31:0] DFP_WORD_ZERO = 32'h0000_0000;

  // Controls that come from pins or from the serial control channel
  typedef struct packed {
    logic dchan_request;
    logic dchan_in_b1;
    logic signalling_rank;
    logic timing_select;
  } dfp_ctl_s;

  // Strobe pin samples, current and previous
  typedef struct packed {
    logic rw;
    logic data_strobe;
    logic address_strobe;
    logic sel_n;
  } dfp_pins_s;

  typedef enum logic {
    DFP_BUS_DS = 1'b0,
    DFP_BUS_SEP = 1'b1
  } dfp_bus_e;

  // Gray order along idle, wait, flag, send
  typedef enum logic [1:0] {
    DFP_IDLE = 2'b00,
    DFP_WAIT = 2'b01,
    DFP_FLAGS = 2'b11,
    DFP_SEND = 2'b10
  } dfp_state_e;
endpackage : dfp_pkg

/* File: rtl/dfp_pins.sv */
// Purpose: Microprocessor port or controllerless controls on four shared pins
// Assumes: All pin inputs synchronous to REF_CLK; APB master holds requests
// Notes: Microport reaches a four-byte mailbox; C-channel controls come over APB
`timescale 1ns/100ps

// Functional notes
// (R1) Mode input high: pins form microport; low: static controls and status.
// (R2) Strobe low at address-strobe rise picks data-strobe mode; reset sets it.
// (R3) Host drives read-not-write high to read, low to write in data-strobe mode.
// (R4) Separate-strobe mode: read-not-write pin is write strobe capturing data.
// (R5) Host holds data strobe during write data; device drives reads while high.
// (R6) Separate-strobe mode: data-strobe pin is read strobe, device outputs data.
// (R7) Address latched at address-strobe fall; in separate mode it is latch enable.
// (R8) Device answers microport accesses only while chip select is low.
// (R9) Network mode: timing select 0 gives fixed timing, 1 keeps adaptive.
// (R10) Terminal mode: same input is access priority, high kept for signalling.
// (R11) D-channel-in-B1 high routes all eight D bits to the B1 slot.
// (R12) While D-in-B1 routing is active, line D-channel carries marks.
// (R13) Control source 0 takes serial channel controls; 1 takes the pins.
// (R14) Serial source ignores control pins but status outputs stay valid.
// (R15) Request high sends opening flag when channel free, otherwise waits.
// (R16) Successful D-channel acquisition is reported on the grant output.
// (R17) Grant follows first flag zero; grant dropping mid-packet means lost.
// (R18) Request low keeps continuous ones on the line D-channel.
// (R19) Bus driven only during a selected read, otherwise released.
module dfp_pins (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CMODE,
  input wire logic RW_OR_TSEL,
  input wire logic STROBE_OR_DCHAN_IN_B1,
  input wire logic LATCH_OR_CSRC,
  input wire logic SEL_N_OR_DCHAN_REQUEST,
  input wire logic [7:0] AD_IN,
  output logic [7:0] AD_OUT,
  output logic AD_OE_N,
  input wire logic DCHAN_FREE,
  input wire logic D_BIT_TICK,
  input wire logic PKT_D_BIT,
  output logic LINE_D_BIT,
  output logic DCHAN_GRANT,
  output logic GRANT_PIN_OUT,
  output logic GRANT_PIN_OE_N,
  output logic TIMING_ADAPTIVE,
  output logic SIGNALLING_RANK,
  output logic DCHAN_B1_ROUTE,
  output logic CTRL_FROM_PINS,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  dfp_pkg::dfp_pins_s pin_r, pin_prev_r;
  dfp_pkg::dfp_bus_e bus_mode_r;
  dfp_pkg::dfp_state_e state_r, state_nxt;
  logic [dfp_pkg::DFP_MP_AW-1:0] addr_r;
  logic [7:0] ad_r;
  logic [7:0] mbox_r [dfp_pkg::DFP_MP_WORDS];
  logic [31:0] ctrl_r;
  logic [3:0] cchan_r;
  logic [2:0] bit_r;
  logic grant_r;
  logic line_r;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic oe_n_r;
  logic [7:0] ad_out_r;
  logic adapt_r, rank_r, b1_r, csrc_r;

  // Registered pin samples so every edge test uses flops, not raw inputs
  dfp_pkg::dfp_pins_s pin_now;
  assign pin_now = '{rw: RW_OR_TSEL, data_strobe: STROBE_OR_DCHAN_IN_B1,
                     address_strobe: LATCH_OR_CSRC, sel_n: SEL_N_OR_DCHAN_REQUEST};

  // Microport decode
  wire micro_on = CMODE; // R1
  wire selected = micro_on & ~pin_r.sel_n; // R8
  wire as_rise = pin_r.address_strobe & ~pin_prev_r.address_strobe;
  wire as_fall = ~pin_r.address_strobe & pin_prev_r.address_strobe;
  wire ds_fall = ~pin_r.data_strobe & pin_prev_r.data_strobe;
  wire wr_rise = pin_r.rw & ~pin_prev_r.rw;
  wire ds_mode = (bus_mode_r == dfp_pkg::DFP_BUS_DS);
  // Data-strobe write ends when the strobe falls with write direction held
  wire wr_ds = ds_mode & ds_fall & ~pin_prev_r.rw; // R3 R5
  // Separate write strobe is active low; data taken at its trailing edge
  wire wr_sep = ~ds_mode & wr_rise; // R4
  wire wr_take = selected & (wr_ds | wr_sep); // R8
  wire rd_ds = ds_mode & pin_r.data_strobe & pin_r.rw; // R3 R5
  wire rd_sep = ~ds_mode & ~pin_r.data_strobe; // R6
  wire rd_drive = selected & (rd_ds | rd_sep); // R19

  // Control source: pins or the serial control channel stand-in
  dfp_pkg::dfp_ctl_s pin_ctl, ser_ctl, eff_ctl;
  assign pin_ctl = '{dchan_request: pin_r.sel_n, dchan_in_b1: pin_r.data_strobe,
                     signalling_rank: pin_r.rw, timing_select: pin_r.rw};
  assign ser_ctl = dfp_pkg::dfp_ctl_s'(cchan_r);
  wire pins_rule = ~micro_on & pin_r.address_strobe; // R13
  // Serial source: pin levels are never looked at, status stays live
  assign eff_ctl = pins_rule ? pin_ctl : ser_ctl; // R13 R14
  wire te_mode = ctrl_r[dfp_pkg::DFP_CTRL_TE_BIT];

  // APB decode
  wire apb_acc = PSEL & PENABLE;
  wire apb_done = apb_acc & pready_r;
  wire hit_ctrl = (PADDR == dfp_pkg::DFP_OFS_CTRL);
  wire hit_cchan = (PADDR == dfp_pkg::DFP_OFS_CCHAN);
  wire hit_stat = (PADDR == dfp_pkg::DFP_OFS_STATUS);
  wire hit_mbox = (PADDR == dfp_pkg::DFP_OFS_MPBOX);
  wire hit_any = hit_ctrl | hit_cchan | hit_stat | hit_mbox;
  wire [31:0] status_word = {20'h0_0000, eff_ctl, 1'b0, te_mode, csrc_r,
                             grant_r, state_r, bus_mode_r, micro_on};
  wire [31:0] mbox_word = {mbox_r[3], mbox_r[2], mbox_r[1], mbox_r[0]};
  wire [31:0] rd_word = hit_ctrl ? ctrl_r :
                        hit_cchan ? {28'h000_0000, cchan_r} :
                        hit_stat ? status_word :
                        hit_mbox ? mbox_word : dfp_pkg::DFP_WORD_ZERO;

  // D-channel access sequencer, terminal mode only
  wire req = te_mode & ~micro_on & eff_ctl.dchan_request & ~eff_ctl.dchan_in_b1;
  wire flag_bit = dfp_pkg::DFP_FLAG[dfp_pkg::DFP_FLAG_LAST - bit_r];
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dfp_pkg::DFP_IDLE: begin
        if (req) begin
          state_nxt = dfp_pkg::DFP_WAIT; // R15
        end
      end
      dfp_pkg::DFP_WAIT: begin
        if (!req) begin
          state_nxt = dfp_pkg::DFP_IDLE;
        end else if (D_BIT_TICK && DCHAN_FREE) begin
          state_nxt = dfp_pkg::DFP_FLAGS; // R15
        end
      end
      dfp_pkg::DFP_FLAGS: begin
        if (!req) begin
          state_nxt = dfp_pkg::DFP_IDLE;
        end else if (!DCHAN_FREE) begin
          state_nxt = dfp_pkg::DFP_WAIT; // R17
        end else if (D_BIT_TICK && bit_r == dfp_pkg::DFP_FLAG_LAST) begin
          state_nxt = dfp_pkg::DFP_SEND;
        end
      end
      dfp_pkg::DFP_SEND: begin
        if (!req) begin
          state_nxt = dfp_pkg::DFP_IDLE;
        end else if (!DCHAN_FREE) begin
          state_nxt = dfp_pkg::DFP_WAIT; // R17
        end
      end
      default: state_nxt = dfp_pkg::DFP_IDLE;
    endcase
  end

  // Line bit: marks unless a flag or packet is under way
  wire line_nxt = eff_ctl.dchan_in_b1 ? 1'b1 : // R12
                  (state_nxt == dfp_pkg::DFP_FLAGS && state_r == dfp_pkg::DFP_WAIT) ?
                  dfp_pkg::DFP_FLAG[7] :
                  (state_r == dfp_pkg::DFP_FLAGS) ? flag_bit :
                  (state_r == dfp_pkg::DFP_SEND) ? PKT_D_BIT : 1'b1; // R18
  // Grant rises on the same edge that puts the first flag zero on the line, falls on loss
  wire grant_nxt = (state_nxt == dfp_pkg::DFP_FLAGS) | (state_nxt == dfp_pkg::DFP_SEND); // R16 R17

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pin_r <= '0;
      pin_prev_r <= '0;
    end else begin
      pin_r <= pin_now;
      pin_prev_r <= pin_r;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      bus_mode_r <= dfp_pkg::DFP_BUS_DS; // R2
    end else if (micro_on && as_rise) begin
      bus_mode_r <= pin_r.data_strobe ? dfp_pkg::DFP_BUS_SEP : dfp_pkg::DFP_BUS_DS; // R2
    end
  end

  // Latch closes on the falling strobe in both bus modes
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      addr_r <= '0;
    end else if (selected && as_fall) begin
      addr_r <= ad_r[dfp_pkg::DFP_MP_AW-1:0]; // R7
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ad_r <= dfp_pkg::DFP_BYTE_ZERO;
    end else begin
      ad_r <= AD_IN;
    end
  end

  // Write uses the data sampled together with the strobe level that shows the closing edge
  genvar gi;
  generate
    for (gi = 0; gi < dfp_pkg::DFP_MP_WORDS; gi++) begin : g_mbox
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          mbox_r[gi] <= dfp_pkg::DFP_BYTE_ZERO;
        end else if (wr_take && addr_r == (dfp_pkg::DFP_MP_AW)'(gi)) begin
          mbox_r[gi] <= ad_r; // R4 R5
        end
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      oe_n_r <= 1'b1;
      ad_out_r <= dfp_pkg::DFP_BYTE_ZERO;
    end else begin
      oe_n_r <= ~rd_drive; // R19 R5 R6
      ad_out_r <= mbox_r[addr_r];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      adapt_r <= 1'b1;
      rank_r <= 1'b0;
      b1_r <= 1'b0;
      csrc_r <= 1'b0;
    end else begin
      adapt_r <= te_mode | eff_ctl.timing_select; // R9
      rank_r <= te_mode & eff_ctl.signalling_rank; // R10
      b1_r <= ~micro_on & eff_ctl.dchan_in_b1; // R11
      csrc_r <= pins_rule; // R13
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_r <= dfp_pkg::DFP_IDLE;
      bit_r <= dfp_pkg::DFP_BIT_ZERO;
      grant_r <= 1'b0;
      line_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      grant_r <= grant_nxt;
      if (state_nxt != dfp_pkg::DFP_FLAGS) begin
        bit_r <= dfp_pkg::DFP_BIT_ZERO;
      end else if (D_BIT_TICK) begin
        bit_r <= bit_r + 3'h1;
      end
      if (D_BIT_TICK) begin
        line_r <= line_nxt;
      end
    end
  end

  // One wait state keeps PRDATA and PREADY straight from flops
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pready_r <= 1'b0;
      prdata_r <= dfp_pkg::DFP_WORD_ZERO;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= apb_acc & ~pready_r;
      prdata_r <= (apb_acc && !PWRITE) ? rd_word : dfp_pkg::DFP_WORD_ZERO;
      pslverr_r <= apb_acc & ~pready_r & ~hit_any;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= dfp_pkg::DFP_CTRL_RST;
      cchan_r <= dfp_pkg::DFP_CCHAN_RST;
    end else if (apb_done && PWRITE) begin
      if (hit_ctrl) begin
        ctrl_r <= PWDATA;
      end
      if (hit_cchan) begin
        cchan_r <= PWDATA[3:0];
      end
    end
  end

  assign AD_OUT = ad_out_r;
  assign AD_OE_N = oe_n_r;
  assign LINE_D_BIT = line_r;
  assign DCHAN_GRANT = grant_r;
  assign GRANT_PIN_OUT = 1'b0;
  // Open drain: pulled low until granted, released to high on grant
  assign GRANT_PIN_OE_N = grant_r;
  assign TIMING_ADAPTIVE = adapt_r;
  assign SIGNALLING_RANK = rank_r;
  assign DCHAN_B1_ROUTE = b1_r;
  assign CTRL_FROM_PINS = csrc_r;
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
endmodule : dfp_pins

/* File: test/dfp_pins_assertions.sv */
// Purpose: Port-level checker for dfp_pins
// Assumes: One clock, RST async active high
// Notes: Bound to every dfp_pins instance
`timescale 1ns/100ps
module dfp_pins_assertions (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CMODE,
  input wire logic SEL_N_OR_DCHAN_REQUEST,
  input wire logic AD_OE_N,
  input wire logic DCHAN_FREE,
  input wire logic D_BIT_TICK,
  input wire logic LINE_D_BIT,
  input wire logic DCHAN_GRANT,
  input wire logic GRANT_PIN_OUT,
  input wire logic GRANT_PIN_OE_N,
  input wire logic DCHAN_B1_ROUTE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [31:0] PRDATA
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence
  a_apb_one_wait: assert property (s_setup ##1 s_access |=> PREADY) else $error("late ready");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
  a_err_zero: assert property (PSLVERR |-> PRDATA == 32'h0000_0000) else $error("err data");
  a_oe_cause: assert property ($fell(AD_OE_N) |-> $past(CMODE, 2)) else $error("oe no cmode");
  a_oe_sel: assert property (!AD_OE_N |-> $past(!SEL_N_OR_DCHAN_REQUEST, 2)) else $error("oe no cs");
  a_grant_cause: assert property ($rose(DCHAN_GRANT) |-> $past(D_BIT_TICK && DCHAN_FREE))
    else $error("grant no free slot");
  a_grant_zero: assert property ($rose(DCHAN_GRANT) |-> !LINE_D_BIT) else $error("no zero");
  a_grant_lost: assert property (DCHAN_GRANT && !DCHAN_FREE |=> !DCHAN_GRANT)
    else $error("grant kept");
  a_grant_pin: assert property (GRANT_PIN_OE_N == DCHAN_GRANT && !GRANT_PIN_OUT)
    else $error("grant pin");
  a_b1_marks: assert property (DCHAN_B1_ROUTE && $past(DCHAN_B1_ROUTE) && D_BIT_TICK |=> LINE_D_BIT)
    else $error("no marks");
endmodule : dfp_pins_assertions
bind dfp_pins dfp_pins_assertions chk_u (.*);

/* File: test/dfp_host.sv */
// Purpose: Far-side host model for the shared bus and line bit pacing
// Assumes: Bench chooses when the host drives
// Notes: Released bus toggles, so a stale value never reads as valid
`timescale 1ns/100ps
module dfp_host (
  input wire logic clk,
  input wire logic [7:0] dev_val,
  input wire logic dev_oe_n,
  input wire logic drv,
  input wire logic [7:0] val,
  output logic [7:0] bus,
  output logic tick
);
  logic [7:0] last = 8'h00;
  logic [2:0] cnt = 3'h0;
  assign bus = !dev_oe_n ? dev_val : drv ? val : ~last;
  initial tick = 1'b0;
  always @(posedge clk) begin
    last <= bus;
    cnt <= cnt + 3'h1;
    tick <= cnt == 3'h7;
  end
endmodule : dfp_host

/* File: test/test_dual_function_host_and_control_pins.sv */
// Purpose: Directed bench for dfp_pins
// Assumes: 10 MHz clock, APB master with waits on PREADY
// Notes: Packet bit tied high; only line flag bits matter
`timescale 1ns/100ps
module test_dual_function_host_and_control_pins;
  logic clk = 1'b0, rst = 1'b1, cmode = 1'b1, rw = 1'b1, ds = 1'b0, as = 1'b0, sel = 1'b1;
  logic free = 1'b1, drv = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, e;
  logic [7:0] val = 8'h00, pa = 8'h00;
  logic [31:0] pwd = 32'h0000_0000, q, prd;
  logic [7:0] ad_in, ad_out;
  logic oe_n, tick, line, gnt, gout, goe, tadp, rank, b1, cfp, prdy, perr;
  int failures = 0, n_compared = 0, n;
  always #50 clk = ~clk;
  dfp_host host_u (.clk(clk), .dev_val(ad_out), .dev_oe_n(oe_n), .drv(drv), .val(val),
    .bus(ad_in), .tick(tick));
  dfp_pins dut_u (.REF_CLK(clk), .RST(rst), .CMODE(cmode), .RW_OR_TSEL(rw),
    .STROBE_OR_DCHAN_IN_B1(ds), .LATCH_OR_CSRC(as), .SEL_N_OR_DCHAN_REQUEST(sel), .AD_IN(ad_in),
    .AD_OUT(ad_out), .AD_OE_N(oe_n), .DCHAN_FREE(free), .D_BIT_TICK(tick), .PKT_D_BIT(1'b1),
    .LINE_D_BIT(line), .DCHAN_GRANT(gnt), .GRANT_PIN_OUT(gout), .GRANT_PIN_OE_N(goe),
    .TIMING_ADAPTIVE(tadp), .SIGNALLING_RANK(rank), .DCHAN_B1_ROUTE(b1), .CTRL_FROM_PINS(cfp),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr));
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task w(input int c);
    repeat (c) @(posedge clk);
  endtask : w
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= wr; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    // Ready is looked at mid-cycle, then the taking edge is let pass
    do begin @(negedge clk); n++; end while (prdy !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    q = prd;
    e = perr;
    @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // Micro access; sep picks the strobe style at the address strobe rise
  task mp(input logic sep, input logic wr, input logic [1:0] a, input logic [7:0] d);
    sel <= 1'b0; ds <= sep; drv <= 1'b1; val <= {6'h00, a}; w(3);
    as <= 1'b1; w(3);
    as <= 1'b0; w(3);
    if (wr) begin val <= d; rw <= 1'b0; ds <= 1'b1; end
    else begin drv <= 1'b0; rw <= 1'b1; ds <= !sep; end
    w(4);
    if (!wr) begin chk("oe", 32'h0, 32'(oe_n)); chk("rd", 32'(d), 32'(ad_out)); end
    ds <= sep; if (sep) rw <= 1'b1; w(3);
    rw <= 1'b1; w(3);
    sel <= 1'b1; drv <= 1'b0; w(4);
    chk("rel", 32'h1, 32'(oe_n));
  endtask : mp
  task end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    #(100 * 20000);
    failures++;
    end_sim();
  end
  initial begin
    w(4); rst <= 1'b0; w(2);
    chk("oe0", 32'h1, 32'(oe_n)); chk("line0", 32'h1, 32'(line));
    apb(1'b0, dfp_pkg::DFP_OFS_CCHAN, 0); chk("cchan", 32'h1, q);
    apb(1'b0, dfp_pkg::DFP_OFS_STATUS, 0); chk("dsmode", 32'h0, q & 32'h2);
    apb(1'b0, 8'h10, 0); chk("err", 32'h1, 32'(e)); chk("errd", 32'h0, q);
    $display("test apb done");
    mp(1'b0, 1'b1, 2'h2, 8'hA5); mp(1'b0, 1'b0, 2'h2, 8'hA5);
    apb(1'b0, dfp_pkg::DFP_OFS_MPBOX, 0); chk("box", 32'hA5, (q >> 16) & 32'hFF);
    mp(1'b1, 1'b1, 2'h1, 8'h3C); mp(1'b1, 1'b0, 2'h1, 8'h3C);
    apb(1'b0, dfp_pkg::DFP_OFS_STATUS, 0); chk("sepmode", 32'h2, q & 32'h2);
    ds <= 1'b0; w(2); ds <= 1'b1; w(6); chk("nocs", 32'h1, 32'(oe_n));
    $display("test microport done");
    cmode <= 1'b0; as <= 1'b1; rw <= 1'b0; ds <= 1'b0; sel <= 1'b0; w(6);
    chk("fixed", 32'h0, 32'(tadp)); chk("pins", 32'h1, 32'(cfp));
    rw <= 1'b1; w(6); chk("adapt", 32'h1, 32'(tadp));
    ds <= 1'b1; w(20); chk("b1", 32'h1, 32'(b1)); chk("mark", 32'h1, 32'(line));
    rw <= 1'b0; as <= 1'b0; w(6); chk("ser", 32'h0, 32'(cfp));
    chk("ignore", 32'h1, 32'(tadp));
    $display("test controls done");
    apb(1'b1, dfp_pkg::DFP_OFS_CTRL, 32'h1);
    as <= 1'b1; rw <= 1'b1; ds <= 1'b0; free <= 1'b0; sel <= 1'b1; w(20);
    chk("nogrant", 32'h0, 32'(gnt)); chk("rank", 32'h1, 32'(rank));
    free <= 1'b1;
    n = 0;
    while (gnt !== 1'b1 && n < 40) begin @(negedge clk); n++; end
    chk("grant", 32'h1, 32'(gnt)); chk("flag0", 32'h0, 32'(line));
    chk("gpin", 32'h1, 32'(goe));
    w(3); free <= 1'b0; w(2); chk("lost", 32'h0, 32'(gnt));
    sel <= 1'b0; free <= 1'b1; w(30); chk("idle", 32'h1, 32'(line));
    $display("test dchannel done");
    end_sim();
  end
endmodule : test_dual_function_host_and_control_pins
